// ===== logic/watch_match_qualifier.sv
// Watchpoint match qualifier: register pairs, read port and deferred watch exception
// Notes on behaviour
// - A qualified match raises the watch exception only while both level flags are zero.
// - A match under either level flag sets the pending flag and the exception waits for both flags to clear.
// - With the global bit set any reference matching the watched address is a hit whatever its space tag.
// - With the global bit clear a hit needs the stored space tag to equal the current one.
// - Each set mask bit removes the matching address bit from the compare.
// - A matching fetch sets the fetch hit flag, which holds until software writes one to it.
// - A matching load sets the load hit flag, which holds until software writes one to it.
// - A matching store sets the store hit flag, which holds until software writes one to it.
// - Bit 31 of the qualifier reads a preset value telling whether another pair follows.
// - The root watch control field reads zero when the virtualization feature is absent.
// - Unused qualifier bits are written as zero by software and always read back as zero.
// - Access addresses compare against the watched doubleword address in base bits 31 to 3.
// - Matches count only for access types whose enable bits are set in the base register.
// - Up to eight pairs are present, each chosen by its own select value.
`timescale 1ns/100ps
`default_nettype none
module watch_match_qualifier
    import watch_pkg::*;
(
    input  wire logic             ref_clk,               // Core clock, 200 MHz
    input  wire logic             reset,                 // Synchronous reset, active high
    input  wire logic [4:0]       reg_num,               // Coprocessor register number
    input  wire logic [SEL_W-1:0] reg_sel,               // Register select, picks the pair
    input  wire logic             reg_wr,                // Register write strobe
    input  wire logic             reg_rd,                // Register read strobe
    input  wire logic [31:0]      reg_wdata,             // Register write data
    input  wire logic             acc_valid,             // Access presented this cycle
    input  wire logic             acc_fetch,             // Access is an instruction fetch
    input  wire logic             acc_load,              // Access is a load
    input  wire logic             acc_store,             // Access is a store
    input  wire logic [31:0]      acc_addr,              // Access virtual address
    input  wire logic [7:0]       cur_space_tag,         // Tag from translation_entry_high
    input  wire logic             exception_level_flag,  // Processor exception level
    input  wire logic             error_level_flag,      // Processor error level
    input  wire logic             pending_clear,         // Software clears the pending flag
    output logic      [31:0]      reg_rdata,             // Register read data
    output logic                  reg_rvalid,            // Read data valid pulse
    output logic                  watch_exception,       // Watch exception request pulse
    output logic                  watch_pending,         // Pending flag for the cause register
    output logic [NUM_PAIRS-1:0]  pair_hit               // Pairs that matched last cycle
);
    logic [31:0]          base_values [NUM_PAIRS];
    logic [31:0]          qual_values [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] pair_match;
    logic                 match_any;
    logic                 levels_set;
    logic                 sel_ok;
    logic [31:0]          next_rdata;
    watch_state_t         state;
    watch_state_t         next_state;
    logic                 next_exception;

    // Select values past the configured pair count address nothing
    assign sel_ok     = 32'(reg_sel) < NUM_PAIRS;
    assign match_any  = |pair_match;
    assign levels_set = exception_level_flag || error_level_flag;

    genvar i;
    generate
        for (i = 0; i < NUM_PAIRS; i++) begin : g_pair
            watch_pair #(
                .HAS_NEXT (i < NUM_PAIRS - 1)
            ) u_pair (
                .ref_clk       (ref_clk),
                .reset         (reset),
                .wr_base       (reg_wr && reg_num == REG_BASE_NUM && 32'(reg_sel) == i),
                .wr_qual       (reg_wr && reg_num == REG_QUAL_NUM && 32'(reg_sel) == i),
                .wr_data       (reg_wdata),
                .acc_valid     (acc_valid),
                .acc_fetch     (acc_fetch),
                .acc_load      (acc_load),
                .acc_store     (acc_store),
                .acc_addr      (acc_addr),
                .cur_space_tag (cur_space_tag),
                .base_value    (base_values[i]),
                .qual_value    (qual_values[i]),
                .match         (pair_match[i])
            );
        end
    endgenerate

    always_comb begin
        next_rdata = RDATA_RESET;
        if (sel_ok && reg_num == REG_BASE_NUM) begin
            next_rdata = base_values[reg_sel];
        end else if (sel_ok && reg_num == REG_QUAL_NUM) begin
            next_rdata = qual_values[reg_sel];
        end
    end

    // Read data is registered so the answer lands one edge after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata  <= RDATA_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // A deferred match outranks a software clear in the same cycle
    always_comb begin
        next_state     = state;
        next_exception = 1'b0;
        case (state)
            ARMED: begin
                if (match_any && levels_set) begin
                    next_state = DEFERRED;
                end else if (match_any) begin
                    next_exception = 1'b1;
                end
            end
            DEFERRED: begin
                if (!levels_set) begin
                    next_exception = 1'b1;
                    next_state     = ARMED;
                end else if (pending_clear && !match_any) begin
                    next_state = ARMED;
                end
            end
            default: begin
                next_state = ARMED;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= ARMED;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            watch_exception <= 1'b0;
            watch_pending   <= 1'b0;
        end else begin
            watch_exception <= next_exception;
            watch_pending   <= next_state == DEFERRED;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pair_hit <= '0;
        end else begin
            pair_hit <= pair_match;
        end
    end

    chk_exc_when_clear: assert property (@(posedge ref_clk) disable iff (reset)
        state == ARMED && match_any && !levels_set |=> watch_exception)
        else $error("clear-level match gave no exception");
    chk_exc_needs_levels: assert property (@(posedge ref_clk) disable iff (reset)
        watch_exception |-> !$past(levels_set))
        else $error("exception raised under a level flag");
    chk_defer_pending: assert property (@(posedge ref_clk) disable iff (reset)
        match_any && levels_set |=> watch_pending && !watch_exception)
        else $error("deferred match not held pending");
    chk_pending_release: assert property (@(posedge ref_clk) disable iff (reset)
        watch_pending && !levels_set |=> watch_exception && !watch_pending)
        else $error("pending exception not released");
    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
        reg_rvalid |-> reg_rdata[27:24] == 4'h0 && reg_rdata[15:12] == 4'h0
                       || $past(reg_num) == REG_BASE_NUM)
        else $error("reserved qualifier bits read nonzero");
    chk_root_ctl_zero: assert property (@(posedge ref_clk) disable iff (reset)
        reg_rvalid && $past(reg_num) == REG_QUAL_NUM && !VIRT_PRESENT
        |-> reg_rdata[29:28] == 2'h0)
        else $error("root watch control read nonzero");
    chk_read_latency: assert property (@(posedge ref_clk) disable iff (reset)
        reg_rd |=> reg_rvalid)
        else $error("read answer missing");

    cov_direct_exception: cover property (@(posedge ref_clk) disable iff (reset)
        match_any && !levels_set ##1 watch_exception);
    cov_deferred_release: cover property (@(posedge ref_clk) disable iff (reset)
        watch_pending ##1 watch_pending ##1 watch_exception);
    cov_pending_cleared: cover property (@(posedge ref_clk) disable iff (reset)
        watch_pending && pending_clear ##1 !watch_pending);
endmodule
`default_nettype wire

// ===== logic/watch_pair.sv
// One base/qualifier register pair with its address compare and sticky hit flags
`timescale 1ns/100ps
`default_nettype none
module watch_pair
    import watch_pkg::*;
#(
    parameter bit HAS_NEXT = 1'b0
) (
    input  wire logic        ref_clk,        // Core clock
    input  wire logic        reset,          // Synchronous reset
    input  wire logic        wr_base,        // Write strobe, base register
    input  wire logic        wr_qual,        // Write strobe, qualifier register
    input  wire logic [31:0] wr_data,        // Write data
    input  wire logic        acc_valid,      // Access presented this cycle
    input  wire logic        acc_fetch,      // Access is an instruction fetch
    input  wire logic        acc_load,       // Access is a load
    input  wire logic        acc_store,      // Access is a store
    input  wire logic [31:0] acc_addr,       // Access virtual address
    input  wire logic [7:0]  cur_space_tag,  // Current space tag
    output logic      [31:0] base_value,     // Base register read value
    output logic      [31:0] qual_value,     // Qualifier register read value
    output logic             match           // Qualified match this cycle
);
    logic [28:0] watched_location;
    logic        en_fetch;
    logic        en_load;
    logic        en_store;
    logic        g_bit;
    logic [1:0]  root_watch_control;
    logic [7:0]  space_tag;
    logic [8:0]  mask;
    logic        hit_fetch;
    logic        hit_load;
    logic        hit_store;
    logic        addr_eq;
    logic        tag_ok;
    logic        fetch_match;
    logic        load_match;
    logic        store_match;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            watched_location <= BASE_RESET;
            en_fetch         <= 1'b0;
            en_load          <= 1'b0;
            en_store         <= 1'b0;
        end else if (wr_base) begin
            watched_location <= wr_data[31:ADDR_LO];
            en_fetch         <= wr_data[FETCH_BIT];
            en_load          <= wr_data[LOAD_BIT];
            en_store         <= wr_data[STORE_BIT];
        end
    end

    // Fields with no defined reset value are cleared anyway, so a first read is predictable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            g_bit              <= 1'b0;
            root_watch_control <= RW_RESET;
            space_tag          <= TAG_RESET;
            mask               <= MASK_RESET;
        end else if (wr_qual) begin
            g_bit              <= wr_data[QUAL_G_BIT];
            space_tag          <= wr_data[QUAL_TAG_HI:QUAL_TAG_LO];
            mask               <= wr_data[QUAL_MASK_HI:QUAL_MASK_LO];
            // Without the virtualization feature the field stays zero so probing sees it absent
            root_watch_control <= VIRT_PRESENT ? wr_data[QUAL_RW_HI:QUAL_RW_LO] : RW_RESET;
        end
    end

    // Mask bits drop the matching address bits out of the compare
    assign addr_eq = ((acc_addr[31:ADDR_LO] ^ watched_location)
                     & ~{20'h00000, mask}) == 29'h00000000;
    assign tag_ok  = g_bit || (space_tag == cur_space_tag);

    assign fetch_match = acc_valid && acc_fetch && en_fetch && addr_eq && tag_ok;
    assign load_match  = acc_valid && acc_load  && en_load  && addr_eq && tag_ok;
    assign store_match = acc_valid && acc_store && en_store && addr_eq && tag_ok;
    assign match       = fetch_match || load_match || store_match;

    // A hit in the same cycle as a write-one clear keeps the flag set
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hit_fetch <= 1'b0;
        end else if (fetch_match) begin
            hit_fetch <= 1'b1;
        end else if (wr_qual && wr_data[FETCH_BIT]) begin
            hit_fetch <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hit_load <= 1'b0;
        end else if (load_match) begin
            hit_load <= 1'b1;
        end else if (wr_qual && wr_data[LOAD_BIT]) begin
            hit_load <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hit_store <= 1'b0;
        end else if (store_match) begin
            hit_store <= 1'b1;
        end else if (wr_qual && wr_data[STORE_BIT]) begin
            hit_store <= 1'b0;
        end
    end

    assign base_value = {watched_location, en_fetch, en_load, en_store};
    assign qual_value = {HAS_NEXT, g_bit, root_watch_control, RSVD_HI, space_tag,
                         RSVD_LO, mask, hit_fetch, hit_load, hit_store};

    chk_fetch_hit_set: assert property (@(posedge ref_clk) disable iff (reset)
        fetch_match |=> hit_fetch) else $error("fetch hit flag not set");
    chk_load_hit_set: assert property (@(posedge ref_clk) disable iff (reset)
        load_match |=> hit_load) else $error("load hit flag not set");
    chk_store_hit_set: assert property (@(posedge ref_clk) disable iff (reset)
        store_match |=> hit_store) else $error("store hit flag not set");
    chk_fetch_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        hit_fetch && !(wr_qual && wr_data[FETCH_BIT]) |=> hit_fetch)
        else $error("fetch hit flag dropped without clear");
    chk_tag_gate: assert property (@(posedge ref_clk) disable iff (reset)
        match |-> g_bit || (space_tag == cur_space_tag))
        else $error("match without global bit or tag equality");
    chk_mask_scope: assert property (@(posedge ref_clk) disable iff (reset)
        match |-> acc_addr[31:12] == watched_location[28:9])
        else $error("unmasked upper address bits differ on match");
endmodule
`default_nettype wire

// ===== logic/watch_pkg.sv
// Constants shared by the watchpoint match qualifier and its per-pair matcher
package watch_pkg;
    localparam int          NUM_PAIRS     = 8;
    localparam int          SEL_W         = 3;
    localparam logic [4:0]  REG_BASE_NUM  = 5'h12;
    localparam logic [4:0]  REG_QUAL_NUM  = 5'h13;
    localparam bit          VIRT_PRESENT  = 1'b0;
    localparam int          QUAL_MORE_BIT = 31;
    localparam int          QUAL_G_BIT    = 30;
    localparam int          QUAL_RW_HI    = 29;
    localparam int          QUAL_RW_LO    = 28;
    localparam int          QUAL_TAG_HI   = 23;
    localparam int          QUAL_TAG_LO   = 16;
    localparam int          QUAL_MASK_HI  = 11;
    localparam int          QUAL_MASK_LO  = 3;
    localparam int          FETCH_BIT     = 2;
    localparam int          LOAD_BIT      = 1;
    localparam int          STORE_BIT     = 0;
    localparam int          ADDR_LO       = 3;
    localparam logic [28:0] BASE_RESET    = 29'h00000000;
    localparam logic [7:0]  TAG_RESET     = 8'h00;
    localparam logic [8:0]  MASK_RESET    = 9'h000;
    localparam logic [1:0]  RW_RESET      = 2'h0;
    localparam logic [3:0]  RSVD_HI       = 4'h0;
    localparam logic [3:0]  RSVD_LO       = 4'h0;
    localparam logic [31:0] RDATA_RESET   = 32'h00000000;
    typedef enum logic {ARMED, DEFERRED} watch_state_t;
endpackage

// ===== verification/access_source.sv
// Pipeline-side model that presents fetch, load and store accesses to the qualifier
`timescale 1ns/100ps
`default_nettype none
module access_source (
    input  wire logic        ref_clk,    // Core clock
    input  wire logic        req,        // Present one access this cycle
    input  wire logic [2:0]  kind,       // Access type as fetch, load, store
    input  wire logic [31:0] addr,       // Address to present
    output logic             acc_valid,  // Access presented
    output logic             acc_fetch,  // Instruction fetch
    output logic             acc_load,   // Load
    output logic             acc_store,  // Store
    output logic      [31:0] acc_addr    // Virtual address
);
    logic [31:0] last_addr = 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (req) begin
            last_addr <= addr;
        end
    end

    // An idle address bus shows the inverse of the last address, so a stale value never matches
    always_comb begin
        acc_valid = req;
        acc_fetch = req & kind[2];
        acc_load  = req & kind[1];
        acc_store = req & kind[0];
        acc_addr  = req ? addr : ~last_addr;
    end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking testbench for the watchpoint match qualifier
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import watch_pkg::*;
    localparam logic [31:0] A = 32'h00001238;
    logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
    logic elf = 1'b0, erf = 1'b0, pending_clear = 1'b0;
    logic [4:0] reg_num = 5'h00;
    logic [SEL_W-1:0] reg_sel = 3'h0;
    logic [31:0] reg_wdata = 32'h00000000, addr = 32'h00000000, reg_rdata, acc_addr;
    logic [2:0] kind = 3'h0;
    logic [7:0] cur_space_tag = 8'h00;
    logic acc_valid, acc_fetch, acc_load, acc_store, reg_rvalid, watch_exception, watch_pending;
    logic [NUM_PAIRS-1:0] pair_hit;
    int err_count = 0, cmp_count = 0;

    access_source access_source_inst (.ref_clk(ref_clk), .req(req), .kind(kind), .addr(addr),
        .acc_valid(acc_valid), .acc_fetch(acc_fetch), .acc_load(acc_load),
        .acc_store(acc_store), .acc_addr(acc_addr));

    watch_match_qualifier watch_match_qualifier_inst (.ref_clk(ref_clk), .reset(reset),
        .reg_num(reg_num), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .acc_valid(acc_valid), .acc_fetch(acc_fetch),
        .acc_load(acc_load), .acc_store(acc_store), .acc_addr(acc_addr),
        .cur_space_tag(cur_space_tag), .exception_level_flag(elf), .error_level_flag(erf),
        .pending_clear(pending_clear), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .watch_exception(watch_exception), .watch_pending(watch_pending), .pair_hit(pair_hit));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs always change a fixed 1 ns after the rising edge
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_write(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] d);
        tick();
        reg_num = num;
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] e);
        tick();
        reg_num = num;
        reg_sel = sel;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        check({31'h0, reg_rvalid}, 32'h1);
        check(reg_rdata, e);
    endtask

    task automatic access(input logic [2:0] k, input logic [31:0] a, input logic [7:0] tag,
                          input logic exc, input logic [7:0] hit);
        tick();
        req = 1'b1;
        kind = k;
        addr = a;
        cur_space_tag = tag;
        tick();
        req = 1'b0;
        check({31'h0, watch_exception}, {31'h0, exc});
        check({24'h0, pair_hit}, {24'h0, hit});
    endtask

    task automatic test_reset_and_fields();
        for (int s = 0; s < NUM_PAIRS; s++) begin
            reg_read(REG_QUAL_NUM, s[2:0], {(s < 7), 31'h0});
        end
        reg_write(REG_QUAL_NUM, 3'h1, 32'hFFFFFFFF);
        reg_read(REG_QUAL_NUM, 3'h1, 32'hC0FF0FF8);
        reg_read(REG_QUAL_NUM, 3'h0, 32'h80000000);
        reg_read(5'h10, 3'h1, 32'h00000000);
    endtask

    task automatic test_global_load();
        reg_write(REG_QUAL_NUM, 3'h2, 32'h40000000);
        reg_write(REG_BASE_NUM, 3'h2, A | 32'h2);
        reg_read(REG_BASE_NUM, 3'h2, A | 32'h2);
        access(3'b001, A, 8'h33, 1'b0, 8'h00);
        access(3'b010, A | 32'h5, 8'h33, 1'b1, 8'h04);
        reg_read(REG_QUAL_NUM, 3'h2, 32'hC0000002);
        reg_write(REG_QUAL_NUM, 3'h2, 32'h40000002);
        reg_read(REG_QUAL_NUM, 3'h2, 32'hC0000000);
    endtask

    task automatic test_tag_fetch();
        reg_write(REG_QUAL_NUM, 3'h5, 32'h005A0000);
        reg_write(REG_BASE_NUM, 3'h5, A | 32'h4);
        access(3'b100, A, 8'h5B, 1'b0, 8'h00);
        access(3'b100, A, 8'h5A, 1'b1, 8'h20);
        reg_read(REG_QUAL_NUM, 3'h5, 32'h805A0004);
    endtask

    task automatic test_mask_store();
        reg_write(REG_QUAL_NUM, 3'h7, 32'h00000008);
        reg_write(REG_BASE_NUM, 3'h7, A | 32'h1);
        access(3'b001, A ^ 32'h8, 8'h00, 1'b1, 8'h80);
        access(3'b001, A ^ 32'h1000, 8'h00, 1'b0, 8'h00);
        reg_read(REG_QUAL_NUM, 3'h7, 32'h00000009);
    endtask

    task automatic test_deferred();
        elf = 1'b1;
        access(3'b001, A, 8'h00, 1'b0, 8'h80);
        check({31'h0, watch_pending}, 32'h1);
        elf = 1'b0;
        erf = 1'b1;
        tick();
        check({30'h0, watch_exception, watch_pending}, 32'h1);
        erf = 1'b0;
        tick();
        check({30'h0, watch_exception, watch_pending}, 32'h2);
        erf = 1'b1;
        access(3'b001, A, 8'h00, 1'b0, 8'h80);
        pending_clear = 1'b1;
        tick();
        pending_clear = 1'b0;
        erf = 1'b0;
        check({30'h0, watch_exception, watch_pending}, 32'h0);
        tick();
        tick();
        check({30'h0, watch_exception, watch_pending}, 32'h0);
    endtask

    // A reset in mid-run must drop a pending exception and the sticky hit flags
    task automatic test_mid_reset();
        elf = 1'b1;
        access(3'b001, A, 8'h00, 1'b0, 8'h80);
        reset = 1'b1;
        tick();
        reset = 1'b0;
        elf = 1'b0;
        check({30'h0, watch_exception, watch_pending}, 32'h0);
        reg_read(REG_QUAL_NUM, 3'h7, 32'h00000000);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        test_reset_and_fields();
        test_global_load();
        test_tag_fetch();
        test_mask_store();
        test_deferred();
        test_mid_reset();
        results();
    end

    // Whole run needs under a hundred cycles, so 4000 means a hang
    initial begin
        repeat (4000) @(posedge ref_clk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
